// *** pwm_ctrl_pkg.sv ***
// package: constants and types of the pulse width modulation control
// Functional notes
// - width deviation in time, zero up to maximum, default 10 us, plus-minus
// - modulated width swings from width minus deviation to width plus it
// - deviation below width minus wmin and below low time minus wmin
// - deviation below high and low time less 0.8 of both edge times
// - external input scales width deviation linearly, negative gives negative
// - duty deviation 0 to 50 percent of period, default 1
// - duty deviation within duty cycle and its complement less wmin share
// - wmin 16 ns small model; large model 5 ns to 4 Vpp, else 8
// - duty deviation below duty and complement less 80 edge time / period
// - external input adds or removes duty deviation share of the period
// - internal rate settable from one step up, default 10 Hz
// - arbitrary shape rate follows its table and stays with it
// - triangle and ramps capped at 200 or 800 kHz; bit shape means bit rate
// - shape sine, square, ramps, triangle, noise, random bits, table; sine
// - source internal, external or a channel; keying refuses channels
// - amplitude at full depth spans maximum to minimum with the input
// - frequency deviation follows the input, negative lowers frequency
// - phase deviation follows the input, negative gives negative phase
// - external keying gives carrier on low trigger, shifted on high
// - keying trigger is a fixed polarity level, slope setting ignored
// - internal keying alternates at keying rate; no channel sources itself
// - one modulation type at a time; pulse modulation only with pulse
package pwm_ctrl_pkg;
  localparam longint CLK_HZ = 200_000_000;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WDEV   = 8'h04;
  localparam logic [7:0] OFS_DDEV   = 8'h08;
  localparam logic [7:0] OFS_FREQ   = 8'h0c;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_WIDTH  = 8'h14;
  localparam logic [7:0] OFS_EDGES  = 8'h18;
  localparam logic [7:0] OFS_AMPL   = 8'h1c;
  localparam logic [7:0] OFS_KRATE  = 8'h20;
  localparam logic [7:0] OFS_MDEV   = 8'h24;
  localparam logic [7:0] OFS_STAT   = 8'h28;
  localparam logic [7:0] OFS_WEFF   = 8'h2c;
  localparam logic [7:0] OFS_ARB    = 8'h40;
  localparam int TYPE_LSB   = 0;
  localparam int SRC_LSB    = 3;
  localparam int SHAPE_LSB  = 5;
  localparam int PULSE_BIT  = 8;
  localparam int DUTY_BIT   = 9;
  localparam int TRAIL_LSB  = 16;
  localparam int REFUSE_BIT = 0;
  localparam int KEY_BIT    = 1;
  localparam longint WDEV_DEF_US = 10;
  localparam logic [31:0] WDEV_RST = 32'(WDEV_DEF_US * 1000);
  localparam logic [6:0] DDEV_RST = 7'h01;
  localparam logic [6:0] DDEV_MAX = 7'h32;
  localparam longint FREQ_DEF_HZ = 10;
  localparam logic [31:0] FREQ_RST = 32'((FREQ_DEF_HZ << 32) / CLK_HZ);
  localparam longint CAP_SMALL_HZ = 200_000;
  localparam longint CAP_LARGE_HZ = 800_000;
  localparam logic [31:0] CAP_SMALL = 32'((CAP_SMALL_HZ << 32) / CLK_HZ);
  localparam logic [31:0] CAP_LARGE = 32'((CAP_LARGE_HZ << 32) / CLK_HZ);
  localparam longint KRATE_DEF_HZ = 10;
  localparam logic [31:0] KRATE_RST = 32'(CLK_HZ / (2 * KRATE_DEF_HZ));
  localparam logic [17:0] WMIN_SMALL_NS = 18'h00010;
  localparam logic [17:0] WMIN_LOW_NS   = 18'h00005;
  localparam logic [17:0] WMIN_HIGH_NS  = 18'h00008;
  localparam logic [15:0] AMPL_LOW_MV   = 16'h0fa0;
  localparam logic [33:0] EDGE_NUM = 34'h4;
  localparam logic [33:0] EDGE_DEN = 34'h5;
  localparam logic [38:0] PCT = 39'h64;
  typedef enum logic [2:0] {
    MOD_OFF = 3'h0, MOD_AM = 3'h1, MOD_FM = 3'h2, MOD_PM = 3'h3,
    MOD_PWM = 3'h4, MOD_PHASE_KEY = 3'h5, MOD_FREQ_KEY = 3'h6
  } mod_type_t;
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0, SRC_EXTERNAL = 2'h1,
    SRC_CHANNEL_ONE = 2'h2, SRC_CHANNEL_TWO = 2'h3
  } src_t;
  typedef enum logic [2:0] {
    SHAPE_SINE = 3'h0, SHAPE_SQUARE = 3'h1, SHAPE_RISING_RAMP = 3'h2,
    SHAPE_FALLING_RAMP = 3'h3, SHAPE_TRIANGLE = 3'h4, SHAPE_NOISE = 3'h5,
    SHAPE_PSEUDO_RANDOM_BITS = 3'h6, SHAPE_TABLE = 3'h7
  } shape_t;
  typedef struct packed {
    logic               ack;
    logic [31:0]        dat;
    mod_type_t          mtype;
    src_t               src;
    shape_t             shape;
    logic               pulse_fn;
    logic               duty_mode;
    logic [31:0]        wdev;
    logic [6:0]         ddev;
    logic [31:0]        freq;
    logic [31:0]        period;
    logic [31:0]        width;
    logic [15:0]        lead;
    logic [15:0]        trail;
    logic [15:0]        ampl;
    logic [31:0]        krate;
    logic [15:0]        mdev;
    logic [31:0]        kcnt;
    logic               kint;
    logic               key;
    logic               refused;
    logic [31:0]        acc;
    logic [15:0]        lfsr;
    logic [15:0][15:0]  table_w;
    logic [15:0]        mod_s1;
    logic [15:0]        mod_s2;
    logic [15:0]        chan_s1;
    logic [15:0]        chan_s2;
    logic               trig_s1;
    logic               trig_s2;
    logic               id_s1;
    logic               id_s2;
    logic [31:0]        pcnt;
    logic [31:0]        mwidth;
    logic               pwm;
    logic signed [33:0] lim;
    logic [31:0]        deff;
    logic [31:0]        mod_out;
  } state_t;
endpackage

// *** pwm_ctrl.sv ***
// module: pulse width modulation control with wishbone registers
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl
  import pwm_ctrl_pkg::*;
#(
  parameter bit LARGE_MODEL = 1'b0
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] mod_in_i,
  input  wire logic [15:0] chan_in_i,
  input  wire logic        trig_i,
  input  wire logic        chan_id_i,
  output logic             pwm_o,
  output logic      [31:0] width_o,
  output logic             key_o,
  output logic      [31:0] mod_o
);
  state_t s;
  state_t n;
  logic [31:0]        w;
  logic [31:0]        fw;
  logic               carry;
  logic [15:0]        ph;
  logic [15:0]        fold;
  logic signed [15:0] tri_v;
  logic signed [15:0] m;
  logic signed [15:0] shp;
  logic signed [32:0] sq;
  logic [17:0]        wmin;
  logic [33:0]        e8;
  logic signed [33:0] hi;
  logic signed [33:0] lo;
  logic signed [33:0] lim;
  logic [38:0]        dset;
  logic [31:0]        deff;
  logic signed [48:0] prod;
  logic signed [33:0] mw;
  logic               keyed;
  logic               ok;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic signed [33:0] smin(input logic signed [33:0] a,
                                              input logic signed [33:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic is_keyed(input mod_type_t t);
    return (t == MOD_PHASE_KEY) || (t == MOD_FREQ_KEY);
  endfunction

  always_comb
  begin
    n = s;
    w = 32'h0;
    ok = 1'b0;
    // synchronisers: first stage read only by the second
    n.mod_s1  = mod_in_i;
    n.mod_s2  = s.mod_s1;
    n.chan_s1 = chan_in_i;
    n.chan_s2 = s.chan_s1;
    n.trig_s1 = trig_i;
    n.trig_s2 = s.trig_s1;
    n.id_s1   = chan_id_i;
    n.id_s2   = s.id_s1;
    // internal modulating oscillator, capped for linear shapes
    fw = s.freq;
    if ((s.shape == SHAPE_TRIANGLE) || (s.shape == SHAPE_RISING_RAMP) ||
        (s.shape == SHAPE_FALLING_RAMP))
    begin
      if (LARGE_MODEL && (s.freq > CAP_LARGE))
        fw = CAP_LARGE;
      else if (!LARGE_MODEL && (s.freq > CAP_SMALL))
        fw = CAP_SMALL;
    end
    {carry, n.acc} = {1'b0, s.acc} + {1'b0, fw};
    // bit shape steps once per cycle of the oscillator
    if ((s.shape == SHAPE_NOISE) || carry)
      n.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[14] ^ s.lfsr[12]
                ^ s.lfsr[3]};
    ph = s.acc[31:16];
    fold = ph[15] ? ~ph : ph;
    tri_v = signed'({fold[14:0], 1'b0} ^ 16'h8000);
    sq = (33'(signed'(tri_v)) * 33'(signed'({1'b0, 16'hffff
         - 16'(tri_v[15] ? -tri_v : tri_v)}))) >>> 15;
    case (s.shape)
      SHAPE_SINE:
        shp = (sq > 33'sd32767) ? 16'sh7fff : signed'(sq[15:0]);
      SHAPE_SQUARE:
        shp = ph[15] ? -16'sh7fff : 16'sh7fff;
      SHAPE_RISING_RAMP:
        shp = signed'(ph ^ 16'h8000);
      SHAPE_FALLING_RAMP:
        shp = signed'(~(ph ^ 16'h8000));
      SHAPE_TRIANGLE:
        shp = tri_v;
      SHAPE_NOISE:
        shp = signed'(s.lfsr);
      SHAPE_PSEUDO_RANDOM_BITS:
        shp = s.lfsr[0] ? 16'sh7fff : -16'sh7fff;
      SHAPE_TABLE:
        shp = signed'(s.table_w[ph[15:12]]);
      default:
        shp = 16'sh0;
    endcase
    case (s.src)
      SRC_INTERNAL:
        m = shp;
      SRC_EXTERNAL:
        m = signed'(s.mod_s2);
      default:
        m = signed'(s.chan_s2);
    endcase
    // deviation limit from minimum width and edge times
    if (!LARGE_MODEL)
      wmin = WMIN_SMALL_NS;
    else if (s.ampl <= AMPL_LOW_MV)
      wmin = WMIN_LOW_NS;
    else
      wmin = WMIN_HIGH_NS;
    e8 = ((34'(s.lead) + 34'(s.trail)) * EDGE_NUM) / EDGE_DEN;
    hi = signed'({2'b00, s.width});
    lo = signed'({2'b00, s.period}) - hi;
    lim = smin(hi, lo) - signed'((e8 > 34'(wmin)) ? e8 : 34'(wmin));
    n.lim = lim;
    if (s.duty_mode)
      dset = (39'(s.ddev) * 39'(s.period)) / PCT;
    else
      dset = 39'(s.wdev);
    if (lim <= 34'sd0)
      deff = 32'h0;
    else if (signed'({1'b0, dset}) < 40'(lim))
      deff = dset[31:0];
    else
      deff = 32'(lim - 34'sd1);
    n.deff = deff;
    prod = (49'(signed'({1'b0, deff})) * 49'(m)) >>> 15;
    mw = hi + 34'(prod);
    // carrier pulse counter; new width taken at each period start
    if ((s.pcnt + 32'h1) >= s.period)
    begin
      n.pcnt = 32'h0;
      n.mwidth = (s.mtype == MOD_PWM) ? mw[31:0] : s.width;
    end
    else
      n.pcnt = s.pcnt + 32'h1;
    n.pwm = n.pcnt < n.mwidth;
    // amplitude, frequency and phase deviation words
    case (s.mtype)
      MOD_AM:
        n.mod_out = 32'(signed'(33'h8000) + ((33'(m)
                    * 33'(signed'({1'b0, s.mdev}))) / 33'sd100));
      MOD_FM, MOD_PM:
        n.mod_out = 32'((49'(signed'({1'b0, s.mdev})) * 49'(m))
                    >>> 15);
      default:
        n.mod_out = 32'h0;
    endcase
    // keying
    keyed = is_keyed(s.mtype);
    if (s.kcnt + 32'h1 >= s.krate)
    begin
      n.kcnt = 32'h0;
      n.kint = ~s.kint;
    end
    else
      n.kcnt = s.kcnt + 32'h1;
    if (!keyed)
      n.key = 1'b0;
    else if (s.src == SRC_EXTERNAL)
      n.key = s.trig_s2;
    else
      n.key = s.kint;
    // wishbone slave, answer one cycle after the request
    n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    n.dat = 32'h0;
    if (n.ack && wb_we_i)
    begin
      case (wb_adr_i)
        OFS_CTRL:
        begin
          w = merge({22'h0, s.duty_mode, s.pulse_fn, s.shape, s.src,
                     s.mtype}, wb_dat_i, wb_sel_i);
          ok = 1'b1;
          if ((mod_type_t'(w[TYPE_LSB +: 3]) == MOD_PWM) && !w[PULSE_BIT])
            ok = 1'b0;
          if (is_keyed(mod_type_t'(w[TYPE_LSB +: 3])) && w[SRC_LSB + 1])
            ok = 1'b0;
          if (src_t'(w[SRC_LSB +: 2]) == (s.id_s2 ? SRC_CHANNEL_TWO
                                                  : SRC_CHANNEL_ONE))
            ok = 1'b0;
          if (w[TYPE_LSB +: 3] > 3'h6)
            ok = 1'b0;
          if (ok)
          begin
            n.mtype = mod_type_t'(w[TYPE_LSB +: 3]);
            n.src = src_t'(w[SRC_LSB +: 2]);
            n.shape = shape_t'(w[SHAPE_LSB +: 3]);
            n.pulse_fn = w[PULSE_BIT];
            n.duty_mode = w[DUTY_BIT];
          end
          else
            n.refused = 1'b1;
        end
        OFS_WDEV:
          n.wdev = merge(s.wdev, wb_dat_i, wb_sel_i);
        OFS_DDEV:
        begin
          w = merge({25'h0, s.ddev}, wb_dat_i, wb_sel_i);
          if (w <= 32'(DDEV_MAX))
            n.ddev = w[6:0];
          else
            n.refused = 1'b1;
        end
        OFS_FREQ:
        begin
          w = merge(s.freq, wb_dat_i, wb_sel_i);
          if (w != 32'h0)
            n.freq = w;
          else
            n.refused = 1'b1;
        end
        OFS_PERIOD:
          n.period = merge(s.period, wb_dat_i, wb_sel_i);
        OFS_WIDTH:
          n.width = merge(s.width, wb_dat_i, wb_sel_i);
        OFS_EDGES:
          {n.trail, n.lead} = merge({s.trail, s.lead}, wb_dat_i, wb_sel_i);
        OFS_AMPL:
          n.ampl = 16'(merge({16'h0, s.ampl}, wb_dat_i, wb_sel_i));
        OFS_KRATE:
          n.krate = merge(s.krate, wb_dat_i, wb_sel_i);
        OFS_MDEV:
          n.mdev = 16'(merge({16'h0, s.mdev}, wb_dat_i, wb_sel_i));
        OFS_STAT:
          if (wb_sel_i[0] && wb_dat_i[REFUSE_BIT])
            n.refused = 1'b0;
        default:
          if ((wb_adr_i & 8'hc3) == OFS_ARB)
            n.table_w[wb_adr_i[5:2]] = 16'(merge({16'h0,
              s.table_w[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i));
      endcase
    end
    else if (n.ack)
    begin
      case (wb_adr_i)
        OFS_CTRL:
          n.dat = {22'h0, s.duty_mode, s.pulse_fn, s.shape, s.src, s.mtype};
        OFS_WDEV:   n.dat = s.wdev;
        OFS_DDEV:   n.dat = {25'h0, s.ddev};
        OFS_FREQ:   n.dat = s.freq;
        OFS_PERIOD: n.dat = s.period;
        OFS_WIDTH:  n.dat = s.width;
        OFS_EDGES:  n.dat = {s.trail, s.lead};
        OFS_AMPL:   n.dat = {16'h0, s.ampl};
        OFS_KRATE:  n.dat = s.krate;
        OFS_MDEV:   n.dat = {16'h0, s.mdev};
        OFS_STAT:   n.dat = {30'h0, s.key, s.refused};
        OFS_WEFF:   n.dat = s.deff;
        default:
          if ((wb_adr_i & 8'hc3) == OFS_ARB)
            n.dat = {16'h0, s.table_w[wb_adr_i[5:2]]};
      endcase
    end
    if (rst_i)
    begin
      n = '0;
      n.wdev = WDEV_RST;
      n.ddev = DDEV_RST;
      n.freq = FREQ_RST;
      n.krate = KRATE_RST;
      n.lfsr = 16'h0001;
      n.mtype = MOD_OFF;
      n.src = SRC_INTERNAL;
      n.shape = SHAPE_SINE;
    end
  end

  always_ff @(posedge clk_i)
    s <= n;

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign pwm_o    = s.pwm;
  assign width_o  = s.mwidth;
  assign key_o    = s.key;
  assign mod_o    = s.mod_out;

  property p_wdev_rst;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> s.wdev == WDEV_RST;
  endproperty
  a_wdev_rst: assert property (p_wdev_rst) else $error("wdev reset");
  property p_dev_lim;
    @(posedge clk_i) disable iff (rst_i)
      s.lim > 34'sd0 |-> 34'(s.deff) < s.lim;
  endproperty
  a_dev_lim: assert property (p_dev_lim) else $error("dev over limit");
  property p_ddev_max;
    @(posedge clk_i) disable iff (rst_i) s.ddev <= DDEV_MAX;
  endproperty
  a_ddev_max: assert property (p_ddev_max) else $error("ddev over max");
  property p_freq_rst;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> s.freq == FREQ_RST;
  endproperty
  a_freq_rst: assert property (p_freq_rst) else $error("freq reset");
  property p_cap;
    @(posedge clk_i) disable iff (rst_i)
      s.shape == SHAPE_TRIANGLE && s.freq > CAP_SMALL && !LARGE_MODEL
      |=> s.acc == $past(s.acc) + CAP_SMALL;
  endproperty
  a_cap: assert property (p_cap) else $error("rate not capped");
  property p_key_src;
    @(posedge clk_i) disable iff (rst_i) is_keyed(s.mtype) |-> !s.src[1];
  endproperty
  a_key_src: assert property (p_key_src) else $error("key on channel");
  sequence s_ext_key;
    is_keyed(s.mtype) && s.src == SRC_EXTERNAL ##1
      is_keyed(s.mtype) && s.src == SRC_EXTERNAL;
  endsequence
  property p_ext_key;
    @(posedge clk_i) disable iff (rst_i)
      s_ext_key |-> s.key == $past(s.trig_s2);
  endproperty
  a_ext_key: assert property (p_ext_key) else $error("key lost");
  property p_pwm_pulse;
    @(posedge clk_i) disable iff (rst_i) s.mtype == MOD_PWM |-> s.pulse_fn;
  endproperty
  a_pwm_pulse: assert property (p_pwm_pulse) else $error("no pulse");
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) s.ack |=> !s.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule
`default_nettype wire

// *** mod_source.sv ***
// partner model: external modulation input, other channel and trigger
`timescale 1ns/1ps
`default_nettype none
module mod_source
(
  input  wire logic        clk_i,
  input  wire logic [15:0] level_i,
  input  wire logic        trig_req_i,
  output logic      [15:0] mod_in_o,
  output logic      [15:0] chan_o,
  output logic             trig_o
);
  logic [7:0] hold_r;
  initial
  begin
    mod_in_o = 16'h0000;
    chan_o   = 16'h0001;
    trig_o   = 1'b0;
    hold_r   = 8'h00;
  end
  // other channel sample changes every cycle, never parks on a value
  always @(posedge clk_i)
  begin
    mod_in_o <= level_i;
    chan_o   <= {chan_o[14:0], chan_o[15] ^ chan_o[13]};
    if (hold_r != 8'h00)
      hold_r <= hold_r - 8'h01;
    else if (trig_req_i != trig_o)
    begin
      trig_o <= trig_req_i;
      hold_r <= 8'h64;
    end
  end
endmodule
`default_nettype wire

// *** pwm_ctrl_bench.sv ***
// self-checking bench of the pulse width modulation control
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_bench;
  import pwm_ctrl_pkg::*;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [31:0] wdat     = 32'h0;
  logic [15:0] level    = 16'h0000;
  logic        trig_req = 1'b0;
  logic        chan_id  = 1'b0;
  logic        obs_r    = 1'b0;
  logic [31:0] obs_v    = 32'h0;
  logic [31:0] rdat;
  logic [31:0] width;
  logic [31:0] modv;
  logic [15:0] mod_in;
  logic [15:0] chan_in;
  logic        ack;
  logic        trig;
  logic        pwm;
  logic        key;
  logic [31:0] q[$];
  int          num_errors      = 0;
  int          samples_checked = 0;
  logic [7:0]  bad_a [7];
  logic [31:0] bad_d [7];
  logic [15:0] lv [3];
  logic [31:0] ew [3];

  pwm_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mod_in_i(mod_in),
    .chan_in_i(chan_in), .trig_i(trig), .chan_id_i(chan_id), .pwm_o(pwm),
    .width_o(width), .key_o(key), .mod_o(modv));
  mod_source src_u (.clk_i(clk_i), .level_i(level), .trig_req_i(trig_req),
    .mod_in_o(mod_in), .chan_o(chan_in), .trig_o(trig));

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    if (q.size() != 0)
      num_errors++;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      num_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic probe(input logic [31:0] v, input logic [31:0] exp);
    q.push_back(exp);
    obs_v <= v;
    obs_r <= 1'b1;
    @(posedge clk_i);
    obs_r <= 1'b0;
    @(posedge clk_i);
  endtask

  // oldest note is compared against each read answer or snapshot
  always @(posedge clk_i)
  begin
    if ((ack === 1'b1 && we === 1'b0) || obs_r === 1'b1)
    begin
      if (q.size() == 0)
        num_errors++;
      else
        check((obs_r === 1'b1) ? obs_v : rdat, q.pop_front());
    end
  end

  initial
  begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    int n;
    logic [31:0] wd;
    logic k;
    void'($urandom(2968));
    bad_a = '{OFS_CTRL, OFS_CTRL, OFS_CTRL, OFS_CTRL, OFS_CTRL,
              OFS_DDEV, OFS_FREQ};
    bad_d = '{32'h4, 32'h1d, 32'h1e, 32'h11, 32'h7, 32'h33, 32'h0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_WDEV, WDEV_RST);
    rd(OFS_DDEV, {25'h0, DDEV_RST});
    rd(OFS_FREQ, FREQ_RST);
    rd(OFS_STAT, 32'h0);
    rd(8'h30, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      wr(bad_a[i], bad_d[i]);
      rd(OFS_STAT, 32'h1);
      wr(OFS_STAT, 32'h1);
    end
    rd(OFS_CTRL, 32'h0);
    rd(OFS_DDEV, {25'h0, DDEV_RST});
    wr(OFS_FREQ, 32'h10000000);
    rd(OFS_FREQ, 32'h10000000);
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_CTRL, 32'h10c | (i << 5));
      rd(OFS_CTRL, 32'h10c | (i << 5));
    end
    for (int c = 0; c < 2; c++)
    begin
      chan_id <= c[0];
      repeat (4) @(posedge clk_i);
      for (int s = 0; s < 4; s++)
      begin
        wr(OFS_CTRL, 32'h104 | (s << 3));
        rd(OFS_STAT, 32'(s == 2 + c));
        wr(OFS_STAT, 32'h1);
      end
    end
    wr(OFS_DDEV, 32'h32);
    rd(OFS_DDEV, 32'h32);
    wr(OFS_PERIOD, 32'd100);
    wr(OFS_WIDTH, 32'd40);
    wr(OFS_EDGES, 32'h0);
    wd = 32'(2 * ($urandom % 12));
    wr(OFS_WDEV, wd);
    wr(OFS_CTRL, 32'h10c);
    rd(OFS_WEFF, wd);
    lv = '{16'h4000, 16'h8000, 16'h0000};
    ew = '{32'd40 + wd / 2, 32'd40 - wd, 32'd40};
    for (int i = 0; i < 3; i++)
    begin
      level <= lv[i];
      repeat (300) @(posedge clk_i);
      probe(width, ew[i]);
      n = 0;
      repeat (100)
      begin
        @(posedge clk_i);
        n += int'(pwm);
      end
      probe(32'(n), ew[i]);
    end
    wr(OFS_EDGES, 32'h00140014);
    wr(OFS_WDEV, 32'd30);
    rd(OFS_WEFF, 32'd7);
    wr(OFS_EDGES, 32'h0);
    wr(OFS_WIDTH, 32'd20);
    rd(OFS_WEFF, 32'd3);
    wr(OFS_WIDTH, 32'd40);
    wr(OFS_DDEV, 32'd5);
    wr(OFS_CTRL, 32'h30c);
    rd(OFS_WEFF, 32'd5);
    level <= 16'h8000;
    repeat (300) @(posedge clk_i);
    probe(width, 32'd35);
    wr(OFS_DDEV, 32'd50);
    rd(OFS_WEFF, 32'd23);
    for (int t = 1; t < 4; t++)
    begin
      wr(OFS_MDEV, (t == 1) ? 32'd100 : 32'd1000);
      wr(OFS_CTRL, 32'h8 | t);
      repeat (20) @(posedge clk_i);
      probe(modv, (t == 1) ? 32'h0 : 32'hfffffc18);
    end
    for (int t = 5; t < 7; t++)
    begin
      wr(OFS_CTRL, 32'h8 | t);
      trig_req <= 1'b1;
      repeat (250) @(posedge clk_i);
      probe({31'h0, key}, 32'h1);
      rd(OFS_STAT, 32'h2);
      trig_req <= 1'b0;
      repeat (250) @(posedge clk_i);
      probe({31'h0, key}, 32'h0);
    end
    wr(OFS_KRATE, 32'd6);
    wr(OFS_CTRL, 32'h5);
    for (int j = 0; j < 3; j++)
    begin
      k = key;
      n = 0;
      while (key === k && n < 100)
      begin
        @(posedge clk_i);
        n++;
      end
    end
    probe(32'(n), 32'd6);
    report_and_stop();
  end
endmodule
`default_nettype wire
